// ---- cods_sensor.v ----
// top of the capacitive sensor: options, scheduling, baseline, detection, APB
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "cods_defs.vh"
module cods_sensor #(
	parameter TICK_CYC = `CODS_TICK_NS / `CODS_CLK_NS,
	parameter XFER_CYC = `CODS_XFER_HALF_NS / `CODS_CLK_NS,
	parameter STRM_CYC = `CODS_STRM_BIT_NS / `CODS_CLK_NS,
	parameter MIN_CYC = (`CODS_MIN_ACT_NS + `CODS_CLK_NS - 1) / `CODS_CLK_NS,
	parameter LATCH_CYC = (`CODS_LATCH_NS + `CODS_CLK_NS - 1) / `CODS_CLK_NS,
	parameter [16:0] HALT0_MS = `CODS_HALT0_MS,
	parameter [16:0] HALT1_MS = `CODS_HALT1_MS
)(
	input wire CLK, // system clock
	input wire RST_N, // async reset, active low
	input wire PSEL, // apb select
	input wire PENABLE, // apb access phase
	input wire PWRITE, // apb direction
	input wire [7:0] PADDR, // apb byte address
	input wire [31:0] PWDATA, // apb write data
	output reg [31:0] PRDATA, // apb read data
	output reg PREADY, // apb ready
	output reg PSLVERR, // apb error, unmapped address
	input wire [7:0] FUSE_BANK0, // fuse array bank zero
	input wire [7:0] FUSE_BANK1, // fuse array bank one
	output reg [7:0] FUSE_PROG0, // bank zero bits to blow
	output reg [7:0] FUSE_PROG1, // bank one bits to blow
	output reg FUSE_PROG_STB, // one-cycle programming strobe
	input wire TRIP_LEVEL_REACHED, // reference comparator, asynchronous
	output wire SENSE_ANTENNA_PIN, // charge/dump switch control
	output wire PROXIMITY_OUTPUT, // proximity pin
	output wire TOUCH_OUTPUT, // touch pin or stream
	output reg IRQ // level interrupt
);
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_CHG = 4'h2;
	localparam [3:0] ST_PROC = 4'h4;
	localparam [3:0] ST_STRM = 4'h8;

	reg [7:0] fz0_a, fz0_b, fz1_a, fz1_b;
	reg [1:0] load_cnt;
	reg opt_ok;
	reg [7:0] opt0, opt1;
	reg trip_a, trip_b;
	reg [31:0] tick_cnt;
	reg tick;
	reg [7:0] ivl_cnt;
	reg due;
	reg [3:0] state;
	reg start;
	reg [15:0] cs;
	reg [15:0] long_term_average;
	reg lta_ok;
	reg [2:0] prox_run, touch_run;
	reg shift_flag;
	reg [16:0] halt_cnt;
	reg [16:0] strm_sh;
	reg [4:0] strm_left;
	reg [31:0] strm_tmr;
	reg strm_bit;
	reg ev_prox, ev_touch, ev_smp;
	reg [2:0] stat, mask;
	reg [7:0] ivl;
	reg [4:0] tnum;
	reg [31:0] rd;
	reg hit;

	wire smp_done;
	wire [15:0] smp_count;

	// option decode from the held copies only
	wire pol = opt0[`CODS_B0_POL];
	wire [1:0] func = opt0[`CODS_B0_FUNC];
	wire [1:0] psel_thr = opt0[`CODS_B0_PROX_THRESHOLD_SEL];
	wire [2:0] tsel = {opt1[`CODS_B1_TTHR2], opt0[`CODS_B0_TOUCH_THRESHOLD_SEL]};
	wire [1:0] power_mode_sel = opt1[`CODS_B1_POWER_MODE_SEL];
	wire [1:0] hsel = opt1[`CODS_B1_HALT];
	// bit 6 of bank one is never looked at
	wire strm_en = opt1[`CODS_B1_STRM];
	wire strm_short = opt1[`CODS_B1_STRM] & opt1[`CODS_B1_SHORT];

	// sample interval per power mode, zero code is boost
	always @* begin
		case (power_mode_sel)
			2'h0: ivl = `CODS_IVL_BP;
			2'h1: ivl = `CODS_IVL_NP;
			2'h2: ivl = `CODS_IVL_LP1;
			default: ivl = `CODS_IVL_LP2;
		endcase
	end

	// touch fraction in 32nds of the baseline
	always @* begin
		case (tsel)
			3'h0: tnum = 5'h02;
			3'h1: tnum = 5'h01;
			3'h2: tnum = 5'h04;
			3'h3: tnum = 5'h06;
			3'h4: tnum = 5'h08;
			3'h5: tnum = 5'h0c;
			3'h6: tnum = 5'h10;
			default: tnum = 5'h14;
		endcase
	end

	// thresholds and baseline distances
	wire [15:0] prox_threshold_sel = `CODS_PROX_THRESHOLD_SEL_BASE << psel_thr;
	wire [20:0] tprod = {5'h00, long_term_average} * {16'h0000, tnum};
	wire [15:0] touch_threshold_sel = tprod[20:5];
	wire [15:0] drop = (long_term_average > cs) ? long_term_average - cs : 16'h0000;
	wire [15:0] rise = (cs > long_term_average) ? cs - long_term_average : 16'h0000;
	wire prox_hit = drop >= prox_threshold_sel;
	wire touch_hit = drop >= touch_threshold_sel;
	wire prox_det = prox_run == `CODS_PROX_N;
	wire touch_det = touch_run == `CODS_TOUCH_N;
	wire shift_now = prox_hit | (rise >= prox_threshold_sel);
	wire [15:0] step_up = (rise[15:4] == 12'h000) ? {15'h0000, rise != 16'h0000} : {4'h0, rise[15:4]};
	wire [15:0] step_dn = (drop[15:4] == 12'h000) ? {15'h0000, drop != 16'h0000} : {4'h0, drop[15:4]};
	wire [16:0] halt_lim = hsel[0] ? HALT1_MS : HALT0_MS;
	wire halt_exp = (hsel == `CODS_HALT_ALWAYS) ? shift_now :
		(hsel != `CODS_HALT_NEVER) & shift_flag & shift_now & (halt_cnt >= halt_lim);

	// fuse pins pass two flops, then are captured on the third clock after release and held
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fz0_a <= 8'h00;
			fz0_b <= 8'h00;
			fz1_a <= 8'h00;
			fz1_b <= 8'h00;
			load_cnt <= 2'h0;
			opt_ok <= 1'b0;
			opt0 <= 8'h00;
			opt1 <= 8'h00;
			trip_a <= 1'b0;
			trip_b <= 1'b0;
		end else begin
			fz0_a <= FUSE_BANK0;
			fz0_b <= fz0_a;
			fz1_a <= FUSE_BANK1;
			fz1_b <= fz1_a;
			trip_a <= TRIP_LEVEL_REACHED;
			trip_b <= trip_a;
			if (!opt_ok) begin
				if (load_cnt == `CODS_LOAD_WAIT) begin
					opt0 <= fz0_b;
					opt1 <= fz1_b;
					opt_ok <= 1'b1;
				end else begin
					load_cnt <= load_cnt + 2'h1;
				end
			end
		end
	end

	// free running ms tick and interval scheduler, independent of charge length
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_cnt <= 32'h00000000;
			tick <= 1'b0;
			ivl_cnt <= 8'h00;
			due <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (tick_cnt == TICK_CYC - 1) begin
				tick_cnt <= 32'h00000000;
				tick <= 1'b1;
			end else begin
				tick_cnt <= tick_cnt + 32'h00000001;
			end
			// a late stream delays one start but never shifts the grid
			if (tick && opt_ok && ivl_cnt >= ivl - 8'h01) begin
				ivl_cnt <= 8'h00;
				due <= 1'b1;
			end else begin
				if (tick && opt_ok)
					ivl_cnt <= ivl_cnt + 8'h01;
				if (start)
					due <= 1'b0;
			end
		end
	end

	// sequencer, baseline, detection and stream
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			start <= 1'b0;
			cs <= 16'h0000;
			long_term_average <= 16'h0000;
			lta_ok <= 1'b0;
			prox_run <= 3'h0;
			touch_run <= 3'h0;
			shift_flag <= 1'b0;
			halt_cnt <= 17'h00000;
			strm_sh <= 17'h00000;
			strm_left <= 5'h00;
			strm_tmr <= 32'h00000000;
			strm_bit <= 1'b0;
			ev_prox <= 1'b0;
			ev_touch <= 1'b0;
			ev_smp <= 1'b0;
		end else begin
			start <= 1'b0;
			ev_prox <= 1'b0;
			ev_touch <= 1'b0;
			ev_smp <= 1'b0;
			if (tick && shift_flag && halt_cnt != {17{1'b1}})
				halt_cnt <= halt_cnt + 17'h00001;
			case (state)
				ST_IDLE: begin
					if (due && !start) begin
						start <= 1'b1;
						state <= ST_CHG;
					end
				end
				ST_CHG: begin
					if (smp_done) begin
						cs <= smp_count;
						state <= ST_PROC;
					end
				end
				ST_PROC: begin
					ev_smp <= 1'b1;
					shift_flag <= shift_now;
					if (!shift_now)
						halt_cnt <= 17'h00000;
					if (!lta_ok) begin
						long_term_average <= cs;
						lta_ok <= 1'b1;
					end else if (halt_exp) begin
						long_term_average <= cs;
						prox_run <= 3'h0;
						touch_run <= 3'h0;
						halt_cnt <= 17'h00000;
						shift_flag <= 1'b0;
					end else begin
						// filter only tracks while no event is standing
						if (!prox_det && !touch_det)
							long_term_average <= long_term_average + step_up - step_dn;
						if (!prox_hit)
							prox_run <= 3'h0;
						else if (!prox_det)
							prox_run <= prox_run + 3'h1;
						if (!touch_hit)
							touch_run <= 3'h0;
						else if (!touch_det)
							touch_run <= touch_run + 3'h1;
						ev_prox <= prox_hit && prox_run == `CODS_PROX_N - 3'h1;
						ev_touch <= touch_hit && touch_run == `CODS_TOUCH_N - 3'h1;
					end
					if (strm_en) begin
						// start bit then sample, msb first
						strm_sh <= strm_short ? {1'b1, cs[7:0], 8'h00} : {1'b1, cs};
						strm_left <= strm_short ? `CODS_SHORT_BITS : `CODS_WORD_BITS;
						strm_tmr <= 32'h00000000;
						state <= ST_STRM;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_STRM: begin
					if (strm_tmr != 32'h00000000) begin
						strm_tmr <= strm_tmr - 32'h00000001;
					end else if (strm_left == 5'h00) begin
						strm_bit <= 1'b0;
						state <= ST_IDLE;
					end else begin
						strm_bit <= strm_sh[16];
						strm_sh <= {strm_sh[15:0], 1'b0};
						strm_left <= strm_left - 5'h01;
						strm_tmr <= STRM_CYC - 1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// read mux and address check for the setup phase
	always @* begin
		rd = 32'h00000000;
		hit = 1'b1;
		if (PADDR == `CODS_OFF_OPT0)
			rd = {24'h000000, opt0};
		else if (PADDR == `CODS_OFF_OPT1)
			rd = {24'h000000, opt1};
		else if (PADDR == `CODS_OFF_SAMPLE)
			rd = {16'h0000, cs};
		else if (PADDR == `CODS_OFF_BASE)
			rd = {16'h0000, long_term_average};
		else if (PADDR == `CODS_OFF_STAT)
			rd = {29'h00000000, stat};
		else if (PADDR == `CODS_OFF_MASK)
			rd = {29'h00000000, mask};
		else if (PADDR == `CODS_OFF_PROG)
			rd = 32'h00000000;
		else if (PADDR == `CODS_OFF_LEVEL)
			rd = {30'h00000000, touch_det, prox_det};
		else
			hit = 1'b0;
	end

	wire apb_wr = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;

	// apb slave with one registered answer cycle, plus status and fuse requests
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h00000000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			stat <= 3'h0;
			mask <= 3'h0;
			IRQ <= 1'b0;
			FUSE_PROG0 <= 8'h00;
			FUSE_PROG1 <= 8'h00;
			FUSE_PROG_STB <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			FUSE_PROG_STB <= 1'b0;
			// error stands only in the answer cycle, beside ready
			PSLVERR <= PSEL & ~PENABLE & ~hit;
			if (PSEL && !PENABLE)
				PRDATA <= PWRITE ? 32'h00000000 : rd;
			if (apb_wr && PADDR == `CODS_OFF_MASK)
				mask <= PWDATA[2:0];
			// new events win over a same-cycle clear
			if (apb_wr && PADDR == `CODS_OFF_STAT)
				stat <= (stat & ~PWDATA[2:0]) | {ev_smp, ev_touch, ev_prox};
			else
				stat <= stat | {ev_smp, ev_touch, ev_prox};
			// only blank bits are ever asked to blow
			if (apb_wr && PADDR == `CODS_OFF_PROG) begin
				FUSE_PROG0 <= PWDATA[7:0] & ~fz0_b;
				FUSE_PROG1 <= PWDATA[15:8] & ~fz1_b;
				FUSE_PROG_STB <= 1'b1;
			end
			IRQ <= |(stat & mask);
		end
	end

	cods_charge_seq #(
		.W(16),
		.HALF_CYC(XFER_CYC)
	) u_chg (
		.clk(CLK),
		.rst_n(RST_N),
		.start(start),
		.trip(trip_b),
		.charge(SENSE_ANTENNA_PIN),
		.done(smp_done),
		.count(smp_count)
	);

	// proximity pin: direct or latched
	cods_out_drv #(
		.MIN_CYC(MIN_CYC),
		.LATCH_CYC(LATCH_CYC)
	) u_prox (
		.clk(CLK),
		.rst_n(RST_N),
		.run(opt_ok),
		.evt(prox_det),
		.latch_md(func[0]),
		.toggle_md(1'b0),
		.act_high(pol),
		.strm_md(1'b0),
		.strm_bit(1'b0),
		.pin(PROXIMITY_OUTPUT)
	);

	// touch pin: direct or toggled, or the stream when enabled
	cods_out_drv #(
		.MIN_CYC(MIN_CYC),
		.LATCH_CYC(LATCH_CYC)
	) u_touch (
		.clk(CLK),
		.rst_n(RST_N),
		.run(opt_ok),
		.evt(touch_det),
		.latch_md(1'b0),
		.toggle_md(func[1]),
		.act_high(pol),
		.strm_md(strm_en),
		.strm_bit(strm_bit),
		.pin(TOUCH_OUTPUT)
	);
endmodule // cods_sensor

// ---- cods_defs.vh ----
// constants shared by the capacitive option decode and sampling block
`ifndef CODS_DEFS_VH
`define CODS_DEFS_VH

// clock and timing figures, each in its own unit
`define CODS_CLK_NS 32'h0000000a
`define CODS_TICK_NS 32'h000f4240
`define CODS_XFER_HALF_NS 32'h000000fa
`define CODS_STRM_BIT_NS 32'h00000fa0
`define CODS_MIN_ACT_NS 32'h000f4240
`define CODS_LATCH_NS 32'h1dcd6500
`define CODS_HALT0_MS 17'h048a8
`define CODS_HALT1_MS 17'h12304

// sample intervals in ms ticks
`define CODS_IVL_BP 8'h09
`define CODS_IVL_NP 8'h32
`define CODS_IVL_LP1 8'h64
`define CODS_IVL_LP2 8'hc8

// option bank zero fields
`define CODS_B0_POL 1
`define CODS_B0_FUNC 3:2
`define CODS_B0_PROX_THRESHOLD_SEL 5:4
`define CODS_B0_TOUCH_THRESHOLD_SEL 7:6
// option bank one fields
`define CODS_B1_TTHR2 0
`define CODS_B1_POWER_MODE_SEL 2:1
`define CODS_B1_HALT 4:3
`define CODS_B1_SHORT 5
`define CODS_B1_STRM 7

// halt selections
`define CODS_HALT_NEVER 2'h2
`define CODS_HALT_ALWAYS 2'h3

// detection, option load and stream constants
`define CODS_PROX_N 3'h6
`define CODS_TOUCH_N 3'h3
`define CODS_PROX_THRESHOLD_SEL_BASE 16'h0002
`define CODS_LOAD_WAIT 2'h2
`define CODS_WORD_BITS 5'h11
`define CODS_SHORT_BITS 5'h09

// register offsets
`define CODS_OFF_OPT0 8'h00
`define CODS_OFF_OPT1 8'h04
`define CODS_OFF_SAMPLE 8'h08
`define CODS_OFF_BASE 8'h0c
`define CODS_OFF_STAT 8'h10
`define CODS_OFF_MASK 8'h14
`define CODS_OFF_PROG 8'h18
`define CODS_OFF_LEVEL 8'h1c

`endif

// ---- cods_charge_seq.v ----
// charge transfer sequencer: pulses the antenna and counts transfers to trip
`timescale 1ns/1ps
`include "cods_defs.vh"
module cods_charge_seq #(
	parameter W = 16,
	parameter HALF_CYC = 25
)(
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire start, // one-cycle start of a charge cycle
	input wire trip, // synchronised trip level flag
	output reg charge, // high charges antenna, low dumps into reference
	output reg done, // one-cycle end of charge cycle
	output reg [W-1:0] count // transfer pulses of the last cycle
);
	reg busy;
	reg [31:0] tmr;
	wire [W-1:0] cnt_max = {W{1'b1}};

	// charge then dump at the transfer rate until trip or saturation
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			tmr <= 32'h00000000;
			charge <= 1'b0;
			done <= 1'b0;
			count <= {W{1'b0}};
		end else begin
			done <= 1'b0;
			if (start) begin
				busy <= 1'b1;
				count <= {W{1'b0}};
				charge <= 1'b0;
				tmr <= HALF_CYC - 1;
			end else if (busy) begin
				if (tmr != 32'h00000000) begin
					tmr <= tmr - 32'h00000001;
				end else begin
					tmr <= HALF_CYC - 1;
					if (!charge) begin
						charge <= 1'b1;
					end else begin
						charge <= 1'b0;
						// stick at the top so a missing trip cannot wrap
						if (count != cnt_max)
							count <= count + {{(W-1){1'b0}}, 1'b1};
						// length follows the pulse count
						if (trip || count == cnt_max) begin
							busy <= 1'b0;
							done <= 1'b1;
						end
					end
				end
			end
		end
	end
endmodule // cods_charge_seq

// ---- cods_out_drv.v ----
// output pin driver: direct, latch or toggle with minimum active time
`timescale 1ns/1ps
`include "cods_defs.vh"
module cods_out_drv #(
	parameter MIN_CYC = 100000,
	parameter LATCH_CYC = 50000000
)(
	input wire clk, // system clock
	input wire rst_n, // async reset, active low
	input wire run, // options loaded
	input wire evt, // event level
	input wire latch_md, // latch function
	input wire toggle_md, // toggle function
	input wire act_high, // polarity, 1 active high
	input wire strm_md, // pin carries serial stream
	input wire strm_bit, // stream bit level
	output reg pin // pin level
);
	reg evt_d;
	reg tog;
	reg act;
	reg want;
	reg [31:0] hold;
	reg [31:0] latch;
	wire rise = evt & ~evt_d;

	// wanted logical level per output function
	always @* begin
		want = evt;
		if (toggle_md)
			want = tog;
		else if (latch_md)
			want = evt | (latch != 32'h00000000);
	end

	// active level never drops before the minimum time
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_d <= 1'b0;
			tog <= 1'b0;
			act <= 1'b0;
			hold <= 32'h00000000;
			latch <= 32'h00000000;
			pin <= 1'b0;
		end else begin
			evt_d <= evt;
			if (rise)
				tog <= ~tog;
			if (rise && latch_md)
				latch <= LATCH_CYC - 1;
			else if (latch != 32'h00000000)
				latch <= latch - 32'h00000001;
			if (want && !act) begin
				act <= 1'b1;
				hold <= MIN_CYC - 1;
			end else if (hold != 32'h00000000) begin
				hold <= hold - 32'h00000001;
			end else begin
				act <= want;
			end
			// logical one drives high; polarity inverts for active low
			if (!run)
				pin <= 1'b0;
			else if (strm_md)
				pin <= strm_bit;
			else
				pin <= act_high ? act : ~act;
		end
	end
endmodule // cods_out_drv

// ---- cods_sensor_chk.sv ----
// port-level assertions for the capacitive sensor block
`timescale 1ns/1ps
`include "cods_defs.vh"
module cods_sensor_chk #(
	parameter XFER_CYC = 25,
	parameter MIN_CYC = 100000
)(
	input wire CLK, // clock
	input wire RST_N, // reset
	input wire PSEL, // select
	input wire PENABLE, // access
	input wire PWRITE, // direction
	input wire [7:0] PADDR, // address
	input wire [31:0] PRDATA, // read data
	input wire PREADY, // ready
	input wire PSLVERR, // error
	input wire [7:0] FUSE_BANK0, // fuses zero
	input wire [7:0] FUSE_BANK1, // fuses one
	input wire [7:0] FUSE_PROG0, // blow zero
	input wire [7:0] FUSE_PROG1, // blow one
	input wire FUSE_PROG_STB, // blow strobe
	input wire SENSE_ANTENNA_PIN, // charge switch
	input wire PROXIMITY_OUTPUT // prox pin
);
	reg [31:0] hi_len;
	reg [31:0] lo_len;
	reg [31:0] p_len;
	reg p_seen;
	// phase lengths; with active-low polarity the first pin change after reset is only the inactive level
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			hi_len <= 32'h0;
			lo_len <= 32'h0;
			p_len <= 32'h0;
			p_seen <= 1'b0;
		end else begin
			hi_len <= SENSE_ANTENNA_PIN ? hi_len + 32'h1 : 32'h0;
			lo_len <= SENSE_ANTENNA_PIN ? 32'h0 : lo_len + 32'h1;
			p_len <= $changed(PROXIMITY_OUTPUT) ? 32'h1 : p_len + 32'h1;
			p_seen <= p_seen | $changed(PROXIMITY_OUTPUT);
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_prog_wr;
		PSEL && PENABLE && PREADY && PWRITE && PADDR == `CODS_OFF_PROG;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> PREADY)
		else $error("ready missing after setup");
	a_ready_cause: assert property (PREADY |-> $past(PSEL && !PENABLE))
		else $error("ready without setup");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error outside access");
	a_err_reads_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_prog_strobe: assert property (s_prog_wr |=> FUSE_PROG_STB ##1 !FUSE_PROG_STB)
		else $error("program strobe not one pulse");
	a_prog_cause: assert property (FUSE_PROG_STB |-> $past(PSEL && PENABLE && PWRITE))
		else $error("program strobe without write");
	a_prog_no_reblow: assert property (FUSE_PROG_STB |-> ((FUSE_PROG0 & FUSE_BANK0) | (FUSE_PROG1 & FUSE_BANK1)) == 8'h00)
		else $error("blown fuse programmed again");
	a_xfer_high: assert property ($fell(SENSE_ANTENNA_PIN) |-> hi_len == XFER_CYC)
		else $error("charge phase length wrong");
	a_xfer_low: assert property ($rose(SENSE_ANTENNA_PIN) |-> lo_len >= XFER_CYC)
		else $error("dump phase too short");
	a_min_active: assert property ($changed(PROXIMITY_OUTPUT) && p_seen |-> p_len >= MIN_CYC)
		else $error("pin level held too briefly");
endmodule // cods_sensor_chk

// ---- cods_afe_model.sv ----
// behavioural charge front end: trips after a set number of charge pulses
`timescale 1ns/1ps
module cods_afe_model #(
	parameter IDLE_CYC = 8
)(
	input wire clk, // clock
	input wire antenna, // charge switch
	input wire [15:0] target, // pulses to trip, 0 never
	output wire trip, // trip flag
	output reg [15:0] pulses = 16'h0000 // charges so far
);
	reg [7:0] idle = 8'h00;
	wire clear = (idle >= IDLE_CYC) && !antenna;
	// long low time discharges the reference, ending the cycle
	always @(posedge clk) begin
		idle <= antenna ? 8'h00 : (clear ? idle : idle + 8'h01);
	end
	// each charge pulse adds to the reference level
	always @(posedge antenna or posedge clear) begin
		pulses <= antenna ? pulses + 16'h0001 : 16'h0000;
	end
	// comparator stays high until the reference is discharged
	assign trip = (target != 16'h0000) && (pulses >= target);
endmodule // cods_afe_model

// ---- cods_sensor_tb.sv ----
// self-checking bench for the capacitive option decode and sampling block
`timescale 1ns/1ps
`include "cods_defs.vh"
module cods_sensor_tb;
	localparam TICK = 40;
	localparam STRM = 4;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg [7:0] bank0 = 8'h00;
	reg [7:0] bank1 = 8'h00;
	reg [15:0] target = 16'h0028;
	wire [31:0] prdata;
	wire [7:0] prog0, prog1;
	wire [15:0] pulses;
	wire pready, pslverr, prog_stb, trip, ant, proximity_output, touch_output, irq;
	reg [31:0] rq;
	reg re;
	integer err_total = 0;
	integer total_checks = 0;
	integer i;
	integer n;
	integer ivl [0:3] = '{9, 50, 100, 200};
	cods_sensor #(.TICK_CYC(TICK), .XFER_CYC(3), .STRM_CYC(STRM), .MIN_CYC(3), .LATCH_CYC(20),
		.HALT0_MS(17'h5), .HALT1_MS(17'h9)) DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .FUSE_BANK0(bank0), .FUSE_BANK1(bank1),
		.FUSE_PROG0(prog0), .FUSE_PROG1(prog1), .FUSE_PROG_STB(prog_stb), .TRIP_LEVEL_REACHED(trip),
		.SENSE_ANTENNA_PIN(ant), .PROXIMITY_OUTPUT(proximity_output), .TOUCH_OUTPUT(touch_output), .IRQ(irq));
	cods_afe_model u_afe (.clk(clk), .antenna(ant), .target(target), .trip(trip),
		.pulses(pulses));
	// free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("ERROR %0t got %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// one transfer waiting on ready with no cycle limit, then an idle cycle so strobes never rewrite in one step
	task apb(input wr, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			// only the watchdog ends a wait that never sees ready
			while (pready !== 1'b1) begin
				@(posedge clk);
			end
			rq = prdata;
			re = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			check(rq, exp);
		end
	endtask
	task start(input [7:0] b0, input [7:0] b1);
		begin
			rst_n <= 1'b0;
			bank0 <= b0;
			bank1 <= b1;
			repeat (2) @(posedge clk);
			rst_n <= 1'b1;
			repeat (6) @(posedge clk);
		end
	endtask
	// a sample is complete once the reference has been discharged
	task smp(input integer cnt);
		begin
			repeat (cnt) @(negedge trip);
			repeat (2) @(posedge clk);
		end
	endtask
	// decode the serial word, sampling each bit in its middle
	task grab(input integer nb, input [15:0] exp);
		integer k;
		reg [15:0] v;
		begin
			v = 16'h0;
			for (k = 0; k < 2000 && touch_output !== 1'b1; k = k + 1) begin
				@(posedge clk);
			end
			repeat (2) @(posedge clk);
			for (k = 0; k < nb; k = k + 1) begin
				repeat (STRM) @(posedge clk);
				v = {v[14:0], touch_output};
				check(ant, 1'b0);
			end
			check(v, exp);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	// watchdog sized well above the expected run of about 45k cycles
	initial begin
		#900000;
		err_total = err_total + 1;
		$display("ERROR %0t watchdog expired", $time);
		complete_run;
	end
	// main sequence
	initial begin
		start(8'h00, 8'h00);
		check({proximity_output, touch_output}, 2'b11);
		bank0 <= 8'h5a;
		smp(1);
		rd(`CODS_OFF_OPT0, 32'h0);
		rd(`CODS_OFF_SAMPLE, 32'h28);
		rd(8'h20, 32'h0);
		check(re, 1'b1);
		apb(1'b1, `CODS_OFF_OPT1, 32'hff);
		rd(`CODS_OFF_OPT1, 32'h0);
		apb(1'b1, `CODS_OFF_PROG, 32'h3cff);
		check({prog1, prog0}, 16'h3ca5);
		rd(`CODS_OFF_MASK, 32'h0);
		bank0 <= 8'h00;
		$display("test options done");
		for (i = 0; i < 4; i = i + 1) begin
			start(8'h00, {3'b000, 2'b10, i[1:0], 1'b0});
			wait (pulses == 16'h0001);
			n = $stime;
			target <= 16'h000a;
			wait (pulses == 16'h0000);
			wait (pulses == 16'h0001);
			n = ($stime - n) / 10;
			check(n, ivl[i] * TICK);
			target <= 16'h0028;
		end
		$display("test power modes done");
		start(8'h22, 8'h11);
		smp(2);
		apb(1'b1, `CODS_OFF_MASK, 32'h3);
		target <= 16'h0014;
		smp(2);
		rd(`CODS_OFF_LEVEL, 32'h0);
		check(irq, 1'b0);
		smp(1);
		rd(`CODS_OFF_LEVEL, 32'h2);
		check(touch_output, 1'b1);
		smp(3);
		rd(`CODS_OFF_LEVEL, 32'h3);
		check({proximity_output, irq}, 2'b11);
		apb(1'b1, `CODS_OFF_STAT, 32'h3);
		rd(`CODS_OFF_STAT, 32'h4); // sample-processed bit stays set
		check(irq, 1'b0);
		target <= 16'h0028;
		smp(2);
		rd(`CODS_OFF_LEVEL, 32'h0);
		check({proximity_output, touch_output}, 2'b00);
		$display("test events done");
		start(8'h0c, 8'h11);
		smp(2);
		target <= 16'h0014;
		smp(6);
		check({proximity_output, touch_output}, 2'b00);
		target <= 16'h0028;
		smp(2);
		check({proximity_output, touch_output}, 2'b10);
		target <= 16'h0014;
		smp(3);
		check(touch_output, 1'b1);
		target <= 16'h0028;
		$display("test output modes done");
		// default halt: second shifted sample readapts the baseline
		start(8'h00, 8'h00);
		smp(2);
		target <= 16'h0014;
		smp(1);
		rd(`CODS_OFF_BASE, 32'h27);
		smp(1);
		rd(`CODS_OFF_BASE, 32'h14);
		// halt always: first shifted sample readapts at once
		start(8'h00, 8'h18);
		smp(2);
		target <= 16'h0014;
		smp(1);
		rd(`CODS_OFF_BASE, 32'h14);
		target <= 16'h0028;
		$display("test baseline halt done");
		start(8'h02, 8'hd0);
		grab(16, 16'h0028);
		start(8'h02, 8'hf0);
		grab(8, 16'h0028);
		$display("test streaming done");
		complete_run;
	end
endmodule // cods_sensor_tb

bind cods_sensor cods_sensor_chk #(.XFER_CYC(XFER_CYC), .MIN_CYC(MIN_CYC)) u_chk (.CLK(CLK), .RST_N(RST_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .FUSE_BANK0(FUSE_BANK0), .FUSE_BANK1(FUSE_BANK1), .FUSE_PROG0(FUSE_PROG0),
	.FUSE_PROG1(FUSE_PROG1), .FUSE_PROG_STB(FUSE_PROG_STB), .SENSE_ANTENNA_PIN(SENSE_ANTENNA_PIN),
	.PROXIMITY_OUTPUT(PROXIMITY_OUTPUT));
